// *** hw/fs_fault_supervisor.sv ***
// Purpose: Fault supervision of a three-phase gate pre-driver
// Assumes: Comparators and drive inputs arrive asynchronously
// Notes:   Clear strobes and config come from same-clock logic
`timescale 1ns/100ps
`default_nettype none
module fs_fault_supervisor
   import fs_pkg::*;
(
   input  wire logic             clk_i,              // 125 MHz clock
   input  wire logic             resetn_i,           // Sync, active low
   input  wire logic [1:0]       battery_low_cmp_i,  // Raw comparators
   input  wire logic [1:0]       logic_low_cmp_i,    // Raw comparators
   input  wire logic             supply_high_cmp_i,  // Raw comparator
   input  wire logic [2:0]       overtemp_cmp_i,     // Raw comparators
   input  wire logic [2:0]       short_low_cmp_i,    // Low-side cmp
   input  wire logic [2:0]       short_high_cmp_i,   // High-side cmp
   input  wire logic [2:0]       phase_low_drive_in_i,  // W,V,U
   input  wire logic [2:0]       phase_high_drive_in_i, // W,V,U
   input  wire fs_pkg::fs_cfg_t  cfg_i,              // Host settings
   input  wire fs_pkg::fs_clear_t clear_i,           // Clear pulses
   input  wire logic             logic_self_test_done_i,
   input  wire logic             logic_self_test_ok_i,
   input  wire logic             analog_self_test_done_i,
   input  wire logic             analog_self_test_ok_i,
   output logic                  logic_self_test_start_o,  // Pulse
   output logic                  analog_self_test_start_o, // Pulse
   output fs_pkg::fs_flags_t     flags_o,            // Sticky flags
   output logic                  fault_indicator_n_o,// Low on fault
   output logic                  power_good_o,       // Logic supply ok
   output logic [2:0]            predriver_en_o,     // Per phase
   output logic                  charge_pump_en_o,   // Pump enable
   output logic                  oscillator_en_o,    // Oscillator enable
   output logic [2:0]            phase_high_gate_out_o, // Gated drive
   output logic [2:0]            phase_low_gate_out_o,  // Gated drive
   output logic [1:0]            short_threshold_o   // To comparators
);

   // ---------------------------------------------------------------
   // Input synchroniser
   // ---------------------------------------------------------------
   logic [FS_RAW_W-1:0] raw;        // Pin inputs gathered
   logic [FS_RAW_W-1:0] sync1;      // First stage, read by sync2 only
   logic [FS_RAW_W-1:0] sync2;      // Safe for logic
   assign raw = {battery_low_cmp_i, logic_low_cmp_i, supply_high_cmp_i,
                 overtemp_cmp_i, short_low_cmp_i, short_high_cmp_i,
                 phase_low_drive_in_i, phase_high_drive_in_i};

   // Two flip-flops per pin
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   logic [1:0] batt_s;              // Synced battery comparators
   logic [1:0] vcl_s;               // Synced logic-supply comparators
   logic       ovc_s;               // Synced supply-high comparator
   logic [2:0] tsd_s;               // Synced overtemp comparators
   logic [2:0] shl_s, shh_s;        // Synced short comparators
   logic [2:0] lo_drv, hi_drv;      // Synced drive inputs
   assign {batt_s, vcl_s, ovc_s, tsd_s, shl_s, shh_s, lo_drv, hi_drv}
      = sync2;

   // ---------------------------------------------------------------
   // Filters
   // ---------------------------------------------------------------
   fs_cfg_t             eff;        // Effective modes
   logic [1:0]          batt_f;     // Filtered battery paths
   logic                ovc_active; // Filtered supply high
   logic [2:0]          tsd_f;      // Filtered overtemp paths
   logic [5:0]          short_f;    // Filtered short paths
   logic [5:0]          short_raw;  // Unfiltered short conditions
   logic [FS_FILT_W-1:0] short_len; // Selected detect time
   logic                short_on;   // Detection enabled

   always_comb begin
      case (cfg_i.short_time)
         2'h0:    short_len = FS_SHORT_CYC_0;
         2'h1:    short_len = FS_SHORT_CYC_1;
         2'h2:    short_len = FS_SHORT_CYC_2;
         default: short_len = FS_SHORT_CYC_3;
      endcase
   end

   assign short_on = (eff.short_action != FS_SHORT_OFF_CODE);
   assign short_raw = {shh_s & hi_drv, shl_s & lo_drv} &
                      {6{short_on}};

   for (genvar i = 0; i < 2; i++) begin : g_batt
      fs_filter #(.W(FS_FILT_W)) u_filt (
         .clk_i    (clk_i),
         .resetn_i (resetn_i),
         .in_i     (batt_s[i]),
         .len_i    (FS_FILT_W'(FS_BATT_FILT_CYC)),
         .out_o    (batt_f[i])
      );
   end

   for (genvar i = 0; i < 3; i++) begin : g_tsd
      fs_filter #(.W(FS_FILT_W)) u_filt (
         .clk_i    (clk_i),
         .resetn_i (resetn_i),
         .in_i     (tsd_s[i]),
         .len_i    (FS_FILT_W'(FS_TSD_FILT_CYC)),
         .out_o    (tsd_f[i])
      );
   end

   // Six short paths with selectable time
   for (genvar i = 0; i < 6; i++) begin : g_short
      fs_filter #(.W(FS_FILT_W)) u_filt (
         .clk_i    (clk_i),
         .resetn_i (resetn_i),
         .in_i     (short_raw[i]),
         .len_i    (short_len),
         .out_o    (short_f[i])
      );
   end

   fs_filter #(.W(FS_FILT_W)) u_ovc (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .in_i     (ovc_s),
      .len_i    (FS_FILT_W'(FS_OVC_FILT_CYC)),
      .out_o    (ovc_active)
   );

   logic batt_active;               // Battery low declared
   logic vcl_active;                // Logic supply low declared
   assign batt_active = |batt_f;
   assign vcl_active  = |vcl_s;

   // ---------------------------------------------------------------
   // Power-up and self-test sequence
   // ---------------------------------------------------------------
   fs_state_t state, next_state;    // Sequencer
   logic      logic_self_test_ok, next_logic_self_test_ok; // Logic test result
   logic      next_lstart, next_astart;

   // Sequencer next state
   always_comb begin
      next_state    = state;
      next_logic_self_test_ok = logic_self_test_ok;
      next_lstart   = 1'b0;
      next_astart   = 1'b0;
      case (state)
         FS_ST_OFF: begin
            if (!vcl_active) begin
               next_state  = FS_ST_LOGIC_SELF_TEST;
               next_lstart = 1'b1;
            end
         end
         FS_ST_LOGIC_SELF_TEST: begin
            // Analogue test runs even after logic failure
            if (logic_self_test_done_i) begin
               next_logic_self_test_ok = logic_self_test_ok_i;
               next_state    = FS_ST_ANALOG_SELF_TEST;
               next_astart   = 1'b1;
            end
         end
         FS_ST_ANALOG_SELF_TEST: begin
            if (analog_self_test_done_i) begin
               next_state = (logic_self_test_ok && analog_self_test_ok_i) ?
                            FS_ST_RUN : FS_ST_FAIL;
            end
         end
         default: ;
      endcase
      if (vcl_active) begin
         next_state  = FS_ST_OFF;
         next_lstart = 1'b0;
         next_astart = 1'b0;
      end
   end

   // Sequencer registers
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state                    <= FS_ST_OFF;
         logic_self_test_ok                 <= 1'b0;
         logic_self_test_start_o  <= 1'b0;
         analog_self_test_start_o <= 1'b0;
      end else begin
         state                    <= next_state;
         logic_self_test_ok                 <= next_logic_self_test_ok;
         logic_self_test_start_o  <= next_lstart;
         analog_self_test_start_o <= next_astart;
      end
   end

   // ---------------------------------------------------------------
   // Flags and effective modes
   // ---------------------------------------------------------------
   fs_cfg_t   next_eff;
   fs_flags_t next_flags;

   // Set wins over clear; clear refused while active
   always_comb begin
      next_flags = flags_o;
      next_eff   = eff;
      next_flags.battery_low = batt_active ||
         (flags_o.battery_low && !clear_i.battery_low);
      // Supply high flag held while active
      next_flags.supply_high = ovc_active ||
         (flags_o.supply_high && !clear_i.supply_high);
      // Overtemp flags held while any active
      next_flags.overtemp = tsd_f |
         (flags_o.overtemp & {3{!(clear_i.overtemp && !(|tsd_f))}});
      // Short flags, cleared only when released
      next_flags.short_flags = short_f |
         (flags_o.short_flags &
          {6{!(clear_i.short_circuit && !(|short_f))}});
      // Battery mode latched only when quiet
      if (!batt_active && !flags_o.battery_low) begin
         next_eff.battery_low_mode = cfg_i.battery_low_mode;
      end
      // Supply high mode latched only when quiet
      if (!ovc_active && !flags_o.supply_high) begin
         next_eff.supply_high_action = cfg_i.supply_high_action;
      end
      // Overtemp mode latched only when quiet
      if (!(|tsd_f) && !(|flags_o.overtemp)) begin
         next_eff.overtemp_action = cfg_i.overtemp_action;
      end
      // Short mode latched only when quiet
      if (!(|short_f) && !(|flags_o.short_flags)) begin
         next_eff.short_action = cfg_i.short_action;
      end
      next_eff.short_threshold = cfg_i.short_threshold;
      next_eff.short_time      = cfg_i.short_time;
   end

   // Flag and mode registers
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         flags_o                <= '0;
         eff.battery_low_mode   <= FS_BATT_MODE_RST;
         eff.supply_high_action <= FS_TIER_ACT_RST;
         eff.overtemp_action    <= FS_TIER_ACT_RST;
         eff.short_action       <= FS_SHORT_ACT_RST;
         eff.short_threshold    <= '0;
         eff.short_time         <= '0;
      end else begin
         flags_o <= next_flags;
         eff     <= next_eff;
      end
   end

   // ---------------------------------------------------------------
   // Shutdown and outputs
   // ---------------------------------------------------------------
   logic [2:0] ovc_off, tsd_off;    // Tier off, {osc, pump, pd}
   logic [2:0] ph_fault, ph_flag;   // Per-phase short state
   logic [2:0] sh_sel, sh_off;      // Phases turned off by shorts
   logic       sh_pump_off;         // Shorts stop the pump
   logic       run, ind_low;
   logic [2:0] next_pd;
   logic       next_cp, next_osc, next_ind_n, next_pg;

   // Supply high and overtemp shutdown tiers
   always_comb begin
      ovc_off = '0;
      tsd_off = '0;
      // Hold code keys on flag, others on level
      if (ovc_active || (flags_o.supply_high &&
          eff.supply_high_action == FS_TIER_HOLD)) begin
         ovc_off = fs_tier_off(eff.supply_high_action);
      end
      // Hold code keys on flags, others on level
      if ((|tsd_f) || ((|flags_o.overtemp) &&
          eff.overtemp_action == FS_TIER_HOLD)) begin
         tsd_off = fs_tier_off(eff.overtemp_action);
      end
   end

   assign ph_fault = short_f[5:3] | short_f[2:0];
   assign ph_flag  = flags_o.short_flags[5:3] |
                     flags_o.short_flags[2:0];
   assign sh_sel = fs_short_hold(eff.short_action) ? ph_flag : ph_fault;

   always_comb begin
      sh_off      = '0;
      sh_pump_off = 1'b0;
      case (eff.short_action)
         3'h1, 3'h2: sh_off = sh_sel;
         3'h3, 3'h4: sh_off = {3{|sh_sel}};
         3'h5, 3'h6: begin
            sh_off      = {3{|sh_sel}};
            sh_pump_off = |sh_sel;
         end
         default: sh_off = '0;
      endcase
   end

   assign run = (state == FS_ST_RUN);

   always_comb begin
      ind_low = (|flags_o.overtemp) || flags_o.supply_high ||
                (|flags_o.short_flags) || !run;
      if (eff.battery_low_mode == FS_BATT_IND_LIVE) begin
         ind_low = ind_low || batt_active;
      end else if (eff.battery_low_mode != FS_BATT_NO_IND) begin
         ind_low = ind_low || flags_o.battery_low;
      end
   end

   // Enable computation
   always_comb begin
      next_pd = {3{run && !vcl_active && !batt_active && !ovc_off[0] &&
                   !tsd_off[0]}} & ~sh_off;
      next_cp = run && !vcl_active && !ovc_off[1] && !tsd_off[1] &&
                !sh_pump_off;
      // Oscillator off while logic supply low
      next_osc   = (state != FS_ST_OFF) && !vcl_active && !ovc_off[2] &&
                   !tsd_off[2];
      next_pg    = !vcl_active;
      next_ind_n = !ind_low;
   end

   // Output registers
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         predriver_en_o        <= '0;
         charge_pump_en_o      <= 1'b0;
         oscillator_en_o       <= 1'b0;
         power_good_o          <= 1'b0;
         fault_indicator_n_o   <= 1'b0;
         phase_high_gate_out_o <= '0;
         phase_low_gate_out_o  <= '0;
         short_threshold_o     <= '0;
      end else begin
         predriver_en_o        <= next_pd;
         charge_pump_en_o      <= next_cp;
         oscillator_en_o       <= next_osc;
         power_good_o          <= next_pg;
         fault_indicator_n_o   <= next_ind_n;
         phase_high_gate_out_o <= hi_drv & next_pd;
         phase_low_gate_out_o  <= lo_drv & next_pd;
         short_threshold_o     <= eff.short_threshold;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   batt_flag_set_a: assert property (batt_active |=>
      flags_o.battery_low) else $error("battery flag not set");
   batt_pd_off_a: assert property (batt_active |=>
      predriver_en_o == 3'h0) else $error("predriver on in battery low");
   ovc_clear_ref_a: assert property (
      ovc_active && clear_i.supply_high |=> flags_o.supply_high)
      else $error("supply high flag cleared while active");
   tsd_ind_low_a: assert property (|flags_o.overtemp |=>
      !fault_indicator_n_o) else $error("indicator high with overtemp");
   logic_low_off_a: assert property (vcl_active |=>
      !power_good_o && !charge_pump_en_o && !oscillator_en_o)
      else $error("circuits on during logic low");
   short_hold_a: assert property (
      eff.short_action == 3'h4 && (|flags_o.short_flags) |=>
      predriver_en_o == 3'h0) else $error("hold code not holding");
   ovc_mode_keep_a: assert property (flags_o.supply_high |=>
      $stable(eff.supply_high_action)) else $error("mode changed early");
   bist_fail_a: assert property (state == FS_ST_FAIL |=>
      !fault_indicator_n_o && !charge_pump_en_o)
      else $error("failed self test enabled outputs");
   short_flag_a: assert property (short_f[0] |=>
      flags_o.short_flags[0]) else $error("short flag not set");

   ovc_recover_c: cover property (flags_o.supply_high && !ovc_active
      && clear_i.supply_high ##1 !flags_o.supply_high);
   short_seen_c: cover property (|flags_o.short_flags);
   bist_pass_c: cover property (state == FS_ST_ANALOG_SELF_TEST ##1 run);

endmodule // fs_fault_supervisor
`default_nettype wire

// *** hw/fs_filter.sv ***
// Purpose: Digital filter, output high after input held high
// Assumes: Input already synchronised to clk_i
// Notes:   Input low clears the output in the next cycle
`timescale 1ns/100ps
`default_nettype none
module fs_filter #(
   parameter int W = 8                       // Counter width
) (
   input  wire logic         clk_i,           // System clock
   input  wire logic         resetn_i,        // Sync reset, active low
   input  wire logic         in_i,            // Level to filter
   input  wire logic [W-1:0] len_i,           // Cycles to confirm
   output logic              out_o            // Confirmed level
);

   logic [W-1:0] cnt;                         // Cycles seen high
   logic [W-1:0] next_cnt;
   logic         next_out;

   // ---------------------------------------------------------------
   // Count while high, confirm at length
   // ---------------------------------------------------------------
   always_comb begin
      next_cnt = '0;
      next_out = 1'b0;
      if (in_i) begin
         next_cnt = (cnt >= len_i) ? cnt : W'(cnt + 1'b1);
         next_out = (W'(cnt + 1'b1) >= len_i);
      end
   end

   // Register stage
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt   <= '0;
         out_o <= 1'b0;
      end else begin
         cnt   <= next_cnt;
         out_o <= next_out;
      end
   end

endmodule // fs_filter
`default_nettype wire

// *** hw/fs_pkg.sv ***
// Purpose: Shared constants and types of the fault supervisor
// Assumes: One 125 MHz clock, filters count in clock cycles
// Notes:   Filter lengths are plain defaults, tune per product
package fs_pkg;

   // ---------------------------------------------------------------
   // Timing constants
   // ---------------------------------------------------------------
   localparam int FS_CLK_NS       = 8;   // Clock period
   localparam int FS_FILT_W       = 8;   // Filter counter width
   localparam int FS_BATT_FILT_NS = 128; // Battery low filter time
   localparam int FS_OVC_FILT_NS  = 128; // Supply high filter time
   localparam int FS_TSD_FILT_NS  = 128; // Overtemp filter time
   // Least times, rounded up to whole cycles
   localparam int FS_BATT_FILT_CYC =
      (FS_BATT_FILT_NS + FS_CLK_NS - 1) / FS_CLK_NS;
   localparam int FS_OVC_FILT_CYC =
      (FS_OVC_FILT_NS + FS_CLK_NS - 1) / FS_CLK_NS;
   localparam int FS_TSD_FILT_CYC =
      (FS_TSD_FILT_NS + FS_CLK_NS - 1) / FS_CLK_NS;
   // Four short detect times, in cycles
   localparam logic [7:0] FS_SHORT_CYC_0 = 8'h04;
   localparam logic [7:0] FS_SHORT_CYC_1 = 8'h08;
   localparam logic [7:0] FS_SHORT_CYC_2 = 8'h10;
   localparam logic [7:0] FS_SHORT_CYC_3 = 8'h20;

   // ---------------------------------------------------------------
   // Reset values and codes
   // ---------------------------------------------------------------
   localparam logic [1:0] FS_BATT_MODE_RST  = 2'h1;
   localparam logic [1:0] FS_TIER_ACT_RST   = 2'h0;
   localparam logic [2:0] FS_SHORT_ACT_RST  = 3'h2;
   localparam logic [1:0] FS_BATT_NO_IND    = 2'h0; // Indicator unused
   localparam logic [1:0] FS_BATT_IND_LIVE  = 2'h2; // Low while active
   localparam logic [1:0] FS_TIER_HOLD      = 2'h3; // Off until clear
   localparam logic [2:0] FS_SHORT_OFF_CODE = 3'h7; // Detection off
   localparam int         FS_RAW_W          = 20;   // Raw pin inputs

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] battery_low_mode;
      logic [1:0] supply_high_action;
      logic [1:0] overtemp_action;
      logic [2:0] short_action;
      logic [1:0] short_threshold;
      logic [1:0] short_time;
   } fs_cfg_t;

   typedef struct packed {
      logic battery_low;
      logic supply_high;
      logic overtemp;
      logic short_circuit;
   } fs_clear_t;

   typedef struct packed {
      logic       battery_low;
      logic       supply_high;
      logic [2:0] overtemp;
      logic [5:0] short_flags; // [5:3] high-side, [2:0] low-side
   } fs_flags_t;

   typedef enum logic [2:0] {
      FS_ST_OFF, FS_ST_LOGIC_SELF_TEST, FS_ST_ANALOG_SELF_TEST, FS_ST_RUN, FS_ST_FAIL
   } fs_state_t;

   // Shutdown tier of a 2-bit action: {osc, pump, predriver}
   function automatic logic [2:0] fs_tier_off(input logic [1:0] act);
      case (act)
         2'h0:    fs_tier_off = 3'h1;
         2'h1:    fs_tier_off = 3'h3;
         2'h2:    fs_tier_off = 3'h7;
         default: fs_tier_off = 3'h3;
      endcase
   endfunction

   // Whether a short action keeps circuits off until flags clear
   function automatic logic fs_short_hold(input logic [2:0] act);
      fs_short_hold = (act == 3'h2) || (act == 3'h4) || (act == 3'h6);
   endfunction

endpackage

// *** sim/fs_selftest_model.sv ***
// Purpose: Self-test engine stand-in answering start pulses
// Assumes: Start is a one-cycle pulse on clk_i
// Notes:   Always passes, verdict after four cycles
`timescale 1ns/100ps
`default_nettype none
module fs_selftest_model (
   input  wire logic clk_i,   // System clock
   input  wire logic start_i, // Start pulse
   output logic      done_o,  // Finished, level
   output logic      ok_o     // Verdict, level
);
   logic [2:0] cnt  = 3'h0;   // Cycles left
   logic       done = 1'b0;   // Finished flag
   assign done_o = done;
   assign ok_o   = 1'b1;
   always @(posedge clk_i) begin
      cnt  <= start_i ? 3'h4 : cnt - {2'h0, cnt != 3'h0};
      done <= !start_i && (done || cnt == 3'h1);
   end
endmodule // fs_selftest_model
`default_nettype wire

// *** sim/test_fs_fault_supervisor.sv ***
// Purpose: Scenario bench of the fault supervisor
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Self-test answered by stand-in models
`timescale 1ns/100ps
`default_nettype none
module test_fs_fault_supervisor;
   import fs_pkg::*;
   logic clk_i = 1'b0, resetn_i = 1'b0;
   logic [1:0] bl = 2'h0, ll = 2'h0;          // Battery, logic cmp
   logic sh = 1'b0, lst, ast, ld, lk, ad, ak, ind, pg, cp, osc;
   logic [2:0] ot = 3'h0, scl = 3'h0, ldi = 3'h0, pd, hg, lg;
   logic [1:0] thr;
   fs_cfg_t cfg;
   fs_clear_t clr;
   fs_flags_t flg;
   int bad_count = 0, tests_run = 0;
   always #4 clk_i = ~clk_i;
   fs_fault_supervisor dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
      .battery_low_cmp_i(bl), .logic_low_cmp_i(ll),
      .supply_high_cmp_i(sh), .overtemp_cmp_i(ot),
      .short_low_cmp_i(scl), .short_high_cmp_i(3'h0),
      .phase_low_drive_in_i(ldi), .phase_high_drive_in_i(3'h0),
      .cfg_i(cfg), .clear_i(clr), .logic_self_test_done_i(ld),
      .logic_self_test_ok_i(lk), .analog_self_test_done_i(ad),
      .analog_self_test_ok_i(ak), .logic_self_test_start_o(lst),
      .analog_self_test_start_o(ast), .flags_o(flg),
      .fault_indicator_n_o(ind), .power_good_o(pg),
      .predriver_en_o(pd), .charge_pump_en_o(cp),
      .oscillator_en_o(osc), .phase_high_gate_out_o(hg),
      .phase_low_gate_out_o(lg), .short_threshold_o(thr));
   fs_selftest_model lm_u (.clk_i(clk_i), .start_i(lst), .done_o(ld),
      .ok_o(lk));
   fs_selftest_model am_u (.clk_i(clk_i), .start_i(ast), .done_o(ad),
      .ok_o(ak));
   task step(input int n); repeat (n) @(posedge clk_i); #1; endtask
   task chk(input logic [10:0] g, input logic [10:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task clear(input fs_clear_t c); clr = c; step(1); clr = '0; step(3);
   endtask
   task t_boot;
      for (int i = 0; i < 300 && ind !== 1'b1; i++) step(1);
      chk({ind, pg, cp, osc, pd}, 7'h7F);
      $display("boot test done");
   endtask
   task t_batt;
      bl = 2'h2; step(30);
      chk({flg.battery_low, ind, cp, osc, pd}, 7'h58);
      clear(4'h8); chk(flg.battery_low, 1'b1);
      bl = 2'h0; step(30); chk({ind, pd}, 4'h7);
      clear(4'h8); chk({flg.battery_low, ind}, 2'h1);
      $display("battery test done");
   endtask
   task t_ovc;
      cfg.supply_high_action = 2'h3; step(3); sh = 1'b1; step(30);
      chk({flg.supply_high, ind, cp, pd}, 6'h20);
      clear(4'h4); chk(flg.supply_high, 1'b1);
      sh = 1'b0; step(30); chk({ind, cp, pd}, 5'h0);
      clear(4'h4); chk({ind, cp, pd}, 5'h1F);
      $display("supply high test done");
   endtask
   task t_hot;
      ot = 3'h4; step(30); chk({flg.overtemp, pd}, 6'h20);
      clear(4'h2); chk(flg.overtemp, 3'h4);
      ot = 3'h0; step(30); chk({ind, pd}, 4'h7);
      clear(4'h2); chk({flg.overtemp, ind}, 4'h1);
      $display("overtemp test done");
   endtask
   task t_short;
      cfg.short_threshold = 2'h3; ldi = 3'h1; scl = 3'h1; step(12);
      chk(thr, 2'h3);
      chk({flg.short_flags, pd, lg}, 12'h070);
      scl = 3'h0; step(8); chk({ind, pd}, 4'h6);
      clear(4'h1); chk({ind, pd, lg}, 7'h79);
      ldi = 3'h0; $display("short test done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      cfg = '0; cfg.battery_low_mode = 2'h1; cfg.short_action = 3'h2;
      clr = '0; step(8); resetn_i = 1'b1;
      t_boot; t_batt; t_ovc; t_hot; t_short; give_verdict;
   end
   initial begin #100000; bad_count++; give_verdict; end
endmodule // test_fs_fault_supervisor
`default_nettype wire
